// ### src/pwm_channel_output_control.sv
// pwm channel output control: counter, compares and pin override logic
// =====================================================================
// Contract
// - In center mode with a nonzero edge/level select, every channel pin is forced to a timer output.
// - In center mode the low edge/level bit picks the polarity of that channel's pin.
// - With select 1:0 in center mode, a match counting up clears the pin, counting down sets it.
// - Edge PWM with select 00 and a running clock keeps the waveform internal, pin untouched.
module pwm_channel_output_control #(
  parameter int NCH = 4
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // register port
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  // port side of the shared pins
  input wire logic [NCH-1:0] port_out,
  input wire logic [NCH-1:0] port_dir,
  // channel pins
  output logic [NCH-1:0] pwm_channel_pin_o,
  output logic [NCH-1:0] pwm_channel_pin_oe,
  // interrupt
  output logic irq
);

  typedef struct packed {
    pwm_pkg::ctrl_t ctrl;
    logic [15:0] modulo;
    logic [15:0] count;
    logic down;
    pwm_pkg::ch_ctrl_t [NCH-1:0] ch;
    logic [NCH-1:0][15:0] match;
    logic [NCH:0] status;
    logic [NCH:0] mask;
    logic [NCH-1:0] wave;
    logic [NCH-1:0] pin_o;
    logic [NCH-1:0] pin_oe;
    logic [15:0] rdata;
    logic irq;
  } state_t;

  state_t s;
  state_t next_s;

  // =====================================================================
  // helpers
  function automatic logic hit(input logic [3:0] a, input logic [3:0] base, input int i);
    hit = (a == base + 4'(i));
  endfunction

  function automatic logic els_on(input logic [1:0] e);
    els_on = (e != pwm_pkg::ELS_OFF);
  endfunction

  // =====================================================================
  // next state
  always_comb begin
    logic running;
    logic ovf;
    logic at_top;
    logic any_center_out;
    logic [NCH:0] events;
    logic [NCH-1:0] m;
    logic [NCH-1:0] drive;
    logic [NCH-1:0] val;
    running = 1'b0;
    ovf = 1'b0;
    at_top = 1'b0;
    any_center_out = 1'b0;
    events = '0;
    m = '0;
    drive = '0;
    val = '0;
    next_s = s;
    next_s.rdata = pwm_pkg::ZERO16;
    running = (s.ctrl.counter_clock_select != pwm_pkg::CLK_OFF);

    // counter: up/down in center mode, otherwise counts up and wraps to zero after reaching modulo
    if (running) begin
      if (s.ctrl.center_aligned) begin
        if (!s.down) begin
          at_top = (s.count >= s.modulo);
          if (at_top) begin
            next_s.down = 1'b1;
            next_s.count = s.count - 16'h0001;
          end else begin
            next_s.count = s.count + 16'h0001;
          end
          if (s.modulo == pwm_pkg::ZERO16) begin
            next_s.count = pwm_pkg::ZERO16;
            next_s.down = 1'b0;
          end
        end else begin
          if (s.count == pwm_pkg::ZERO16) begin
            next_s.down = 1'b0;
            next_s.count = 16'h0001;
          end else begin
            next_s.count = s.count - 16'h0001;
          end
          // overflow at the bottom turn in center mode
          ovf = (s.count == pwm_pkg::ZERO16);
        end
      end else begin
        next_s.down = 1'b0;
        if (s.count >= s.modulo) begin
          next_s.count = pwm_pkg::ZERO16;
          ovf = 1'b1;
        end else begin
          next_s.count = s.count + 16'h0001;
        end
      end
    end

    for (int i = 0; i < NCH; i++) begin
      m[i] = running && (s.count == s.match[i]);
      if (els_on(s.ch[i].edge_level_select)) begin
        any_center_out = any_center_out | s.ctrl.center_aligned;
      end
    end

    // internal waveform per channel, runs whether or not the pin is driven
    for (int i = 0; i < NCH; i++) begin
      if (s.ctrl.center_aligned) begin
        if (m[i]) begin
          // low select bit chooses polarity
          if (s.ch[i].edge_level_select[0]) begin
            next_s.wave[i] = !s.down;
          end else begin
            next_s.wave[i] = s.down;
          end
        end
      end else if (running) begin
        // edge pwm: high from overflow, low at match (low-select flips)
        if (ovf) begin
          next_s.wave[i] = !s.ch[i].edge_level_select[0];
        end else if (m[i]) begin
          next_s.wave[i] = s.ch[i].edge_level_select[0];
        end
      end
      events[pwm_pkg::ST_CH_LO + i] = m[i];
    end
    events[pwm_pkg::ST_OVF] = ovf;

    // pin ownership
    for (int i = 0; i < NCH; i++) begin
      if (any_center_out) begin
        drive[i] = 1'b1;
        val[i] = next_s.wave[i];
      end else if (els_on(s.ch[i].edge_level_select)) begin
        drive[i] = 1'b1;
        val[i] = next_s.wave[i];
      end else begin
        // select 00: wave stays internal, port keeps the pin
        drive[i] = port_dir[i];
        val[i] = port_out[i];
      end
    end
    next_s.pin_o = val;
    next_s.pin_oe = drive;

    // register writes
    if (wr) begin
      if (addr == pwm_pkg::OFS_CTRL) begin
        next_s.ctrl.counter_clock_select = wdata[pwm_pkg::CTRL_CLK_LO +: 2];
        next_s.ctrl.center_aligned = wdata[pwm_pkg::CTRL_CENTER];
      end
      if (addr == pwm_pkg::OFS_MODULO) begin
        next_s.modulo = wdata;
      end
      if (addr == pwm_pkg::OFS_COUNT) begin
        next_s.count = pwm_pkg::ZERO16;
        next_s.down = 1'b0;
      end
      if (addr == pwm_pkg::OFS_STATUS) begin
        next_s.status = s.status & ~wdata[NCH:0];
      end
      if (addr == pwm_pkg::OFS_MASK) begin
        next_s.mask = wdata[NCH:0];
      end
      for (int i = 0; i < NCH; i++) begin
        if (hit(addr, pwm_pkg::OFS_CH_BASE, i)) begin
          next_s.ch[i].edge_level_select = wdata[pwm_pkg::CH_ELS_LO +: 2];
          next_s.ch[i].channel_mode_select = wdata[pwm_pkg::CH_MODE_LO +: 2];
        end
        if (hit(addr, pwm_pkg::OFS_MATCH_BASE, i)) begin
          next_s.match[i] = wdata;
        end
      end
    end
    // set wins over write-one-to-clear
    next_s.status = next_s.status | events;
    next_s.irq = |(next_s.status & next_s.mask);

    // register reads, data one cycle later; unmapped reads zero
    if (rd) begin
      if (addr == pwm_pkg::OFS_CTRL) begin
        next_s.rdata = {13'h0000, s.ctrl.center_aligned, s.ctrl.counter_clock_select};
      end
      if (addr == pwm_pkg::OFS_MODULO) begin
        next_s.rdata = s.modulo;
      end
      if (addr == pwm_pkg::OFS_COUNT) begin
        next_s.rdata = s.count;
      end
      if (addr == pwm_pkg::OFS_STATUS) begin
        next_s.rdata = 16'(s.status);
      end
      if (addr == pwm_pkg::OFS_MASK) begin
        next_s.rdata = 16'(s.mask);
      end
      for (int i = 0; i < NCH; i++) begin
        if (hit(addr, pwm_pkg::OFS_CH_BASE, i)) begin
          next_s.rdata = {12'h000, s.ch[i].channel_mode_select, s.ch[i].edge_level_select};
        end
        if (hit(addr, pwm_pkg::OFS_MATCH_BASE, i)) begin
          next_s.rdata = s.match[i];
        end
      end
    end
  end

  // =====================================================================
  // state register
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
      s.modulo <= pwm_pkg::MODULO_RST;
    end else begin
      s <= next_s;
    end
  end

  assign rdata = s.rdata;
  assign pwm_channel_pin_o = s.pin_o;
  assign pwm_channel_pin_oe = s.pin_oe;
  assign irq = s.irq;

endmodule

// ### src/pwm_pkg.sv
// package: register map, field layout and types of the pwm channel block
package pwm_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  // register offsets
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_MODULO = 4'h1;
  localparam logic [3:0] OFS_COUNT = 4'h2;
  localparam logic [3:0] OFS_STATUS = 4'h3;
  localparam logic [3:0] OFS_MASK = 4'h4;
  localparam logic [3:0] OFS_CH_BASE = 4'h8;
  localparam logic [3:0] OFS_MATCH_BASE = 4'hC;
  // control field positions
  localparam int CTRL_CLK_LO = 0;
  localparam int CTRL_CENTER = 2;
  // channel control field positions
  localparam int CH_ELS_LO = 0;
  localparam int CH_MODE_LO = 2;
  // status bits: overflow at 0, channel events from 1 up
  localparam int ST_OVF = 0;
  localparam int ST_CH_LO = 1;
  // reset values and field encodings
  localparam logic [15:0] MODULO_RST = 16'h0000;
  localparam logic [15:0] ZERO16 = 16'h0000;
  localparam logic [1:0] ELS_OFF = 2'h0;
  localparam logic [1:0] ELS_CLEAR_UP = 2'h2;
  localparam logic [1:0] CLK_OFF = 2'h0;
  localparam logic [1:0] MODE_EDGE_PWM = 2'h2;

  typedef struct packed {
    logic [1:0] counter_clock_select;
    logic center_aligned;
  } ctrl_t;

  typedef struct packed {
    logic [1:0] channel_mode_select;
    logic [1:0] edge_level_select;
  } ch_ctrl_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;
endpackage

// ### testbench/pwm_chk.sv
// port-level assertions of the pwm channel block
module pwm_chk #(parameter int NCH = 4) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // register port
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [15:0] rdata,
  // pins and interrupt
  input wire logic [NCH-1:0] port_out,
  input wire logic [NCH-1:0] port_dir,
  input wire logic [NCH-1:0] pwm_channel_pin_o,
  input wire logic [NCH-1:0] pwm_channel_pin_oe,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // shadow of the control writes
  logic cen;
  logic [1:0] sel0;
  logic [NCH:0] msk;
  logic [3:0] anysel;
  logic drv;
  logic port0;
  assign drv = cen && (|anysel);
  assign port0 = !drv && sel0 == 2'h0;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cen <= 1'b0;
      sel0 <= 2'h0;
      msk <= '0;
      anysel <= 4'h0;
    end else if (wr) begin
      if (addr == 4'h0) cen <= wdata[2];
      if (addr == 4'h4) msk <= wdata[NCH:0];
      if (addr == 4'h8) sel0 <= wdata[1:0];
      if (addr[3:2] == 2'h2) anysel[addr[1:0]] <= |wdata[1:0];
    end
  end
  // ==========
  // assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  AST_RD_IDLE: assert property (!$past(rd) |-> rdata == 16'h0000)
    else $error("rdata not idle");
  AST_UNMAPPED: assert property ($past(rd && addr inside {4'h5, 4'h6}) |-> rdata == 16'h0000)
    else $error("unmapped read not zero");
  AST_MASK_RD: assert property ($past(rd && addr == 4'h4) |-> rdata[NCH:0] == msk)
    else $error("mask readback");
  AST_CENTER_OE: assert property (drv && $past(drv) |-> &pwm_channel_pin_oe)
    else $error("center pins not driven");
  AST_PORT_OE: assert property (port0 && $past(port0) && $past(nrst)
    |-> pwm_channel_pin_oe[0] == $past(port_dir[0]))
    else $error("pin enable not from port");
  AST_PORT_O: assert property (port0 && $past(port0) && $past(nrst)
    |-> pwm_channel_pin_o[0] == $past(port_out[0]))
    else $error("pin value not from port");
  AST_SEL_DRIVE: assert property (sel0 != 2'h0 && $past(sel0 != 2'h0) |-> pwm_channel_pin_oe[0])
    else $error("selected pin not driven");
  AST_IRQ_MASK: assert property (msk == '0 && $past(msk == '0) |-> !irq)
    else $error("masked irq high");
  cover property (drv && $past(drv));
  cover property ($rose(irq));
  cover property ($rose(pwm_channel_pin_o[0]) && pwm_channel_pin_oe[0]);
endmodule
bind pwm_channel_output_control pwm_chk #(.NCH(NCH)) u_chk (.ref_clk, .nrst, .addr, .wdata,
  .wr, .rd, .rdata, .port_out, .port_dir, .pwm_channel_pin_o, .pwm_channel_pin_oe, .irq);

// ### testbench/pwm_load.sv
// load on the channel pins: level seen on each wire
module pwm_load #(parameter int NCH = 4) (
  // clock and pins
  input wire logic ref_clk,
  input wire logic [NCH-1:0] pin_o,
  input wire logic [NCH-1:0] pin_oe,
  output logic [NCH-1:0] pin_lvl
);
  timeunit 1ns;
  timeprecision 1ps;
  // no pull: an undriven pin wanders every cycle
  logic [NCH-1:0] flt = '0;
  always @(posedge ref_clk) flt <= ~flt;
  assign pin_lvl = (pin_oe & pin_o) | (~pin_oe & flt);
endmodule

// ### testbench/tb_pwm_channel_output_control.sv
// bench for the pwm channel output control block
module tb_pwm_channel_output_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [3:0] port_out = 4'h0;
  logic [3:0] port_dir = 4'h0;
  logic [15:0] rdata;
  logic [3:0] pin_o, pin_oe, pin_lvl;
  logic irq;
  int miscompares = 0;
  int samples_checked = 0;
  always #5 ref_clk = ~ref_clk;
  pwm_channel_output_control #(.NCH(4)) dut (.ref_clk(ref_clk), .nrst(nrst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .port_out(port_out), .port_dir(port_dir),
    .pwm_channel_pin_o(pin_o), .pwm_channel_pin_oe(pin_oe), .irq(irq));
  pwm_load #(.NCH(4)) load (.ref_clk(ref_clk), .pin_o(pin_o), .pin_oe(pin_oe), .pin_lvl(pin_lvl));
  // ==========
  // bus and compare tasks
  task automatic tally_and_finish;
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  task automatic bw(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask
  task automatic br(input logic [3:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    @(negedge ref_clk);
    d = rdata;
  endtask
  // ==========
  // scenarios
  task automatic t_edge;
    logic [15:0] d;
    int n;
    br(4'h5, d);
    chk(16'h0000, d);
    @(posedge ref_clk);
    port_dir <= 4'h1;
    port_out <= 4'h1;
    bw(4'h8, 16'h0008);
    bw(4'h1, 16'h0010);
    bw(4'hC, 16'h0008);
    bw(4'h4, 16'h0001);
    br(4'h4, d);
    chk(16'h0001, d);
    bw(4'h0, 16'h0001);
    n = 0;
    while (irq !== 1'b1 && n < 40) begin
      @(negedge ref_clk);
      chk(16'h0003, {14'h0, pin_oe[0], pin_lvl[0]});
      n++;
    end
    chk(16'h0001, 16'(n < 40));
    // a missing overflow ends the run here, after 40 sampled cycles
    if (n >= 40) begin
      tally_and_finish();
    end
    br(4'h3, d);
    chk(16'h0001, d & 16'h0001);
    bw(4'h3, 16'h0001);
    @(negedge ref_clk);
    chk(16'h0000, {15'h0, irq});
    bw(4'h4, 16'h0000);
    bw(4'h8, 16'h000A);
    n = 0;
    repeat (17) begin
      @(negedge ref_clk);
      chk(16'h0001, {15'h0, pin_oe[0]});
      n += 32'(pin_lvl[0] === 1'b1);
    end
    // one period: high until the match, low after it
    chk(16'h0001, 16'(n inside {[7:9]}));
  endtask
  task automatic t_center;
    bw(4'h0, 16'h0000);
    bw(4'h1, 16'h0008);
    bw(4'hD, 16'h0005);
    bw(4'hC, 16'h0005);
    bw(4'h9, 16'h0001);
    port_dir <= 4'h0;
    bw(4'h0, 16'h0005);
    bw(4'h2, 16'h0000);
    repeat (8) @(posedge ref_clk);
    @(negedge ref_clk);
    chk(16'h000F, {12'h0, pin_oe});
    chk(16'h0002, {14'h0, pin_lvl[1:0]});
    repeat (7) @(posedge ref_clk);
    @(negedge ref_clk);
    chk(16'h0001, {14'h0, pin_lvl[1:0]});
  endtask
  initial begin
    repeat (12) @(posedge ref_clk);
    nrst <= 1'b1;
    t_edge();
    t_center();
    tally_and_finish();
  end
endmodule
